/* verilog/sfr_guard_cfg.svh */
/*
  Named constants for the special function register access guard:
  group field positions, register byte addresses, reset values and the
  fixed read value that a refused read returns.
  Assumes a 12-bit APB byte address in which each register is one
  aligned 32-bit word.
*/
// Operation
// - Contactless OS reads firewall config, owns its registers.
// - Contactless OS hardware access follows firewall rights.
// - System mode reaches MMU, system, firewall, hardware.
// - User hardware access follows current segment rights.
// - General CPU registers open in every mode.
// - Program status high readable in contactless, user.
// - Clock source select readable in contactless OS.
// - MMU configuration refused outside system mode.
// - System protect registers never readable.
// - Random number register never writable.
// - Crypto key registers never readable, writes allowed.
// - Segment table address resets to zero.
// - Security reset values fixed, never loadable.
// - Memory partition fixed, no configuration path.
// - System mode may relocate the segment table.
// - Segment table memory uses ordinary memory rights.
// - Exchange area placed and sized by system, boot and test modes only.
// - Boot and test modes reach every group except MMU.
`ifndef SFR_GUARD_CFG_SVH
`define SFR_GUARD_CFG_SVH

// Field positions inside the byte address.
`define GRP_MSB 11
`define GRP_LSB 8
`define IDX_MSB 6
`define IDX_LSB 2
`define HW_HIGH_BIT 7

// Group codes held in the group field.
`define GRP_CODE_GEN 4'h0
`define GRP_CODE_SYS 4'h1
`define GRP_CODE_MMU 4'h2
`define GRP_CODE_FW 4'h3
`define GRP_CODE_CLOS 4'h4
`define GRP_CODE_HW 4'h5

// Registers with special treatment.
`define ADDR_PSW_HIGH 12'h104
`define ADDR_PROTECT_0 12'h110
`define ADDR_PROTECT_1 12'h114
`define ADDR_PROTECT_2 12'h118
`define ADDR_CLK_SEL 12'h500
`define ADDR_RANDOM 12'h504
`define ADDR_KEY_A 12'h508
`define ADDR_KEY_D 12'h50C

// Registers held inside the guard.
`define ADDR_EXCH_BASE 12'h108
`define ADDR_EXCH_SIZE 12'h10C
`define ADDR_STAB_LO 12'h200
`define ADDR_STAB_HI 12'h204
`define ADDR_FW_LO 12'h300
`define ADDR_FW_HI 12'h304

// Reset values and fixed read answers.
`define RST_STAB 16'h0000
`define RST_EXCH 16'h0000
`define RST_FW 32'h0000_0000
`define DENY_RDATA 32'h0000_0000
`define ZERO32 32'h0000_0000

`endif

/* verilog/sfr_guard_pkg.sv */
/*
  Types shared by the access guard modules: CPU modes, register groups,
  internal register selectors and the bus answer states.
  Assumes nothing of its surroundings.
*/
package sfr_guard_pkg;
  // CPU mode as reported by the core; other codes are illegal.
  typedef enum logic [2:0] {MODE_BOOT = 3'b000, MODE_TEST = 3'b001,
    MODE_CLOS = 3'b010, MODE_SYS = 3'b011, MODE_USER = 3'b100} cpu_mode_e;
  // Register group of an address.
  typedef enum logic [2:0] {GRP_GENERAL = 3'b000, GRP_SYSMGMT = 3'b001,
    GRP_MMU = 3'b010, GRP_FWCFG = 3'b011, GRP_CLOS = 3'b100,
    GRP_HWCOMP = 3'b101, GRP_NONE = 3'b110} sfr_group_e;
  // Registers that live inside the guard.
  typedef enum logic [2:0] {OWN_NONE = 3'b000, OWN_EXCH_BASE = 3'b001,
    OWN_EXCH_SIZE = 3'b010, OWN_STAB_LO = 3'b011, OWN_STAB_HI = 3'b100,
    OWN_FW_LO = 3'b101, OWN_FW_HI = 3'b110} own_reg_e;
  // Bus answer sequencing.
  typedef enum logic {ST_IDLE = 1'b0, ST_ANSWER = 1'b1} apb_state_e;
endpackage

/* verilog/sfr_class_if.sv */
/*
  Interface that carries an address to the group decoder and the
  classification back to the guard.
  Assumes one decoder and one user per instance.
*/
`timescale 1ns/1ps
interface sfr_class_if;
  import sfr_guard_pkg::*;
  logic [11:0] addr; // Byte address under test.
  sfr_group_e grp; // Register group of the address.
  logic [4:0] hwIdx; // Hardware register index inside its group.
  own_reg_e own; // Guard register selected, if any.
  logic isPsw; // Program status high.
  logic isProt; // One of the system protect registers.
  logic isClk; // Clock source select.
  logic isRng; // Random number value.
  logic isKey; // One of the crypto key registers.
  modport decoder(input addr, output grp, hwIdx, own, isPsw, isProt,
    isClk, isRng, isKey);
  modport user(output addr, input grp, hwIdx, own, isPsw, isProt,
    isClk, isRng, isKey);
endinterface

/* verilog/guard_reg.sv */
/*
  One guarded configuration register with a fixed reset constant.
  Assumes the caller only raises the write enable for permitted writes.
*/
`timescale 1ns/1ps
module guard_reg #(
  parameter int W = 16,
  parameter logic [W-1:0] RST = '0
) (
  // Clock and reset.
  input wire logic clk,
  input wire logic rst_b,
  // Write side.
  input wire logic we,
  input wire logic [W-1:0] wdata,
  // Stored value.
  output logic [W-1:0] q
);
  logic [W-1:0] val_d; // Next register value.

  // Load on a permitted write, otherwise hold.
  always_comb
  begin
    val_d = we ? wdata : q;
  end

  // The reset value is a constant of the design and no port loads it.
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
      q <= RST;
    else
      q <= val_d;
  end
endmodule

/* verilog/sfr_group_decode.sv */
/*
  Address classifier: sorts an address into its register group and
  flags the registers that carry fixed read or write restrictions.
  Assumes the byte address layout of the configuration header.
*/
`timescale 1ns/1ps
`include "sfr_guard_cfg.svh"
module sfr_group_decode (
  // Address in, classification out.
  sfr_class_if.decoder cls
);
  import sfr_guard_pkg::*;

  // Group and special register decode, purely combinational.
  always_comb
  begin
    cls.hwIdx = cls.addr[`IDX_MSB:`IDX_LSB];
    cls.isPsw = (cls.addr == `ADDR_PSW_HIGH);
    cls.isProt = (cls.addr == `ADDR_PROTECT_0) ||
      (cls.addr == `ADDR_PROTECT_1) || (cls.addr == `ADDR_PROTECT_2);
    cls.isClk = (cls.addr == `ADDR_CLK_SEL);
    cls.isRng = (cls.addr == `ADDR_RANDOM);
    cls.isKey = (cls.addr == `ADDR_KEY_A) || (cls.addr == `ADDR_KEY_D);
    unique case (cls.addr[`GRP_MSB:`GRP_LSB])
      `GRP_CODE_GEN: cls.grp = GRP_GENERAL;
      `GRP_CODE_SYS: cls.grp = GRP_SYSMGMT;
      `GRP_CODE_MMU: cls.grp = GRP_MMU;
      `GRP_CODE_FW: cls.grp = GRP_FWCFG;
      `GRP_CODE_CLOS: cls.grp = GRP_CLOS;
      // Only the lower half of the hardware page is populated.
      `GRP_CODE_HW: cls.grp = cls.addr[`HW_HIGH_BIT] ? GRP_NONE : GRP_HWCOMP;
      default: cls.grp = GRP_NONE;
    endcase
    unique case (cls.addr)
      `ADDR_EXCH_BASE: cls.own = OWN_EXCH_BASE;
      `ADDR_EXCH_SIZE: cls.own = OWN_EXCH_SIZE;
      `ADDR_STAB_LO: cls.own = OWN_STAB_LO;
      `ADDR_STAB_HI: cls.own = OWN_STAB_HI;
      `ADDR_FW_LO: cls.own = OWN_FW_LO;
      `ADDR_FW_HI: cls.own = OWN_FW_HI;
      default: cls.own = OWN_NONE;
    endcase
  end
endmodule

/* verilog/sfr_mode_access_guard.sv */
/*
  Access guard between the CPU core and the special function register
  space. The core reaches the space as an APB3 master; the guard checks
  every transfer against the current CPU mode, the firewall rights and
  the rights of the executing memory segment, serves its own security
  registers and forwards permitted transfers to the downstream register
  space.
  Assumes the mode and segment rights are stable during a transfer and
  that the downstream space answers reads in the cycle it is strobed.
*/
`timescale 1ns/1ps
`include "sfr_guard_cfg.svh"
module sfr_mode_access_guard (
  // Clock and reset.
  input wire logic sys_clk,
  input wire logic rst_b,
  // APB slave port from the core.
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Security attributes from the core and the segment lookup.
  input wire sfr_guard_pkg::cpu_mode_e cpuMode,
  input wire logic [31:0] segReadRights,
  input wire logic [31:0] segWriteRights,
  // Downstream register space.
  output logic sfrReadEn,
  output logic sfrWriteEn,
  output logic [11:0] sfrAddr,
  output logic [31:0] sfrWdata,
  input wire logic [31:0] sfrRdata,
  // Configuration handed to the memory management unit.
  output logic [31:0] segTableAddr,
  output logic [15:0] exchangeBase,
  output logic [15:0] exchangeSize
);
  import sfr_guard_pkg::*;

  // Classification of the current address.
  sfr_class_if cls();

  // Answer sequencing state.
  apb_state_e state_q;
  apb_state_e state_d;

  // Registered answer towards the core.
  logic [31:0] prdata_q;
  logic [31:0] prdata_d;
  logic pslverr_q;
  logic pslverr_d;

  // Decoded mode flags.
  logic modeLegal; // Mode code is one of the five modes.
  logic modeOpen; // Boot or test mode.
  logic modeSys; // System mode.
  logic modeClos; // Contactless operating system mode.
  logic modeUser; // User mode.

  // Permission results for the current address.
  logic readOk; // A read here would be granted.
  logic writeOk; // A write here would be granted.
  logic allowed; // The transfer in hand is granted.

  // Transfer qualifiers.
  logic accessPhase; // First access cycle of a transfer.
  logic ownWrite; // Granted write in the first access cycle, to any target.

  // Guard register contents.
  logic [15:0] stabLo;
  logic [15:0] stabHi;
  logic [15:0] exchBase;
  logic [15:0] exchSize;
  logic [31:0] fwRightsLow;
  logic [31:0] fwRightsHigh;
  logic [31:0] ownRdata; // Read value of the selected guard register.

  // Address classifier.
  assign cls.addr = paddr;

  sfr_group_decode u_decode (
    .cls(cls)
  );

  // Mode decode; a code outside the five modes grants nothing.
  always_comb
  begin
    modeLegal = 1'b1;
    modeOpen = 1'b0;
    modeSys = 1'b0;
    modeClos = 1'b0;
    modeUser = 1'b0;
    unique case (cpuMode)
      MODE_BOOT: modeOpen = 1'b1;
      MODE_TEST: modeOpen = 1'b1;
      MODE_CLOS: modeClos = 1'b1;
      MODE_SYS: modeSys = 1'b1;
      MODE_USER: modeUser = 1'b1;
      default: modeLegal = 1'b0;
    endcase
  end

  // Permission table. Group grants come first, then boot and test
  // open everything mapped, and last the fixed per-register limits,
  // which hold in every mode including boot and test.
  always_comb
  begin
    readOk = 1'b0;
    writeOk = 1'b0;
    unique case (cls.grp)
      GRP_GENERAL:
      begin
        // General CPU registers need no firewall or segment check.
        readOk = modeLegal;
        writeOk = modeLegal;
      end
      GRP_SYSMGMT:
      begin
        // System management, including the exchange area registers.
        readOk = modeSys;
        writeOk = modeSys;
        if ((modeClos || modeUser) && cls.isPsw)
          readOk = 1'b1;
      end
      GRP_MMU:
      begin
        // Segmentation setup belongs to system mode alone.
        readOk = modeSys;
        writeOk = modeSys;
      end
      GRP_FWCFG:
      begin
        // Firewall setup: system writes, contactless OS may look.
        readOk = modeSys || modeClos;
        writeOk = modeSys;
      end
      GRP_CLOS:
      begin
        // Registers of the contactless operating system.
        readOk = modeClos;
        writeOk = modeClos;
      end
      GRP_HWCOMP:
      begin
        if (modeSys)
        begin
          readOk = 1'b1;
          writeOk = 1'b1;
        end
        else if (modeClos)
        begin
          // Low word grants reads, high word grants writes.
          readOk = fwRightsLow[cls.hwIdx] || cls.isClk;
          writeOk = fwRightsHigh[cls.hwIdx];
        end
        else if (modeUser)
        begin
          // Rights of the segment the code is fetched from.
          readOk = segReadRights[cls.hwIdx];
          writeOk = segWriteRights[cls.hwIdx];
        end
      end
      GRP_NONE:
      begin
        // Unmapped address: nothing granted in any mode.
        readOk = 1'b0;
        writeOk = 1'b0;
      end
    endcase
    if (modeOpen && (cls.grp != GRP_NONE))
    begin
      readOk = 1'b1;
      writeOk = 1'b1;
    end
    // Segmentation setup stays closed to boot and test mode as well, so
    // only system code can ever move the segment table.
    if ((cls.grp == GRP_MMU) && !modeSys)
    begin
      readOk = 1'b0;
      writeOk = 1'b0;
    end
    if (cls.isProt)
      readOk = 1'b0;
    if (cls.isRng)
      writeOk = 1'b0;
    if (cls.isKey)
      readOk = 1'b0;
  end

  // A transfer is judged once, in its first access cycle.
  assign accessPhase = psel && penable && (state_q == ST_IDLE);
  assign allowed = pwrite ? writeOk : readOk;
  assign ownWrite = accessPhase && pwrite && writeOk;

  // Downstream strobes only for granted transfers outside the guard;
  // a refused write never reaches the target register.
  assign sfrReadEn = accessPhase && !pwrite && readOk &&
    (cls.own == OWN_NONE);
  assign sfrWriteEn = ownWrite && (cls.own == OWN_NONE);
  assign sfrAddr = paddr;
  assign sfrWdata = pwdata;

  // Segment table pointer, cleared by reset so no segment is enabled.
  guard_reg #(
    .W(16),
    .RST(`RST_STAB)
  ) u_stab_lo (
    .clk(sys_clk),
    .rst_b(rst_b),
    .we(ownWrite && (cls.own == OWN_STAB_LO)),
    .wdata(pwdata[15:0]),
    .q(stabLo)
  );

  guard_reg #(
    .W(16),
    .RST(`RST_STAB)
  ) u_stab_hi (
    .clk(sys_clk),
    .rst_b(rst_b),
    .we(ownWrite && (cls.own == OWN_STAB_HI)),
    .wdata(pwdata[15:0]),
    .q(stabHi)
  );

  // Exchange area window, writable in system, boot and test mode only.
  guard_reg #(
    .W(16),
    .RST(`RST_EXCH)
  ) u_exch_base (
    .clk(sys_clk),
    .rst_b(rst_b),
    .we(ownWrite && (cls.own == OWN_EXCH_BASE)),
    .wdata(pwdata[15:0]),
    .q(exchBase)
  );

  guard_reg #(
    .W(16),
    .RST(`RST_EXCH)
  ) u_exch_size (
    .clk(sys_clk),
    .rst_b(rst_b),
    .we(ownWrite && (cls.own == OWN_EXCH_SIZE)),
    .wdata(pwdata[15:0]),
    .q(exchSize)
  );

  // Firewall rights, reset to grant nothing.
  guard_reg #(
    .W(32),
    .RST(`RST_FW)
  ) u_fw_low (
    .clk(sys_clk),
    .rst_b(rst_b),
    .we(ownWrite && (cls.own == OWN_FW_LO)),
    .wdata(pwdata),
    .q(fwRightsLow)
  );

  guard_reg #(
    .W(32),
    .RST(`RST_FW)
  ) u_fw_high (
    .clk(sys_clk),
    .rst_b(rst_b),
    .we(ownWrite && (cls.own == OWN_FW_HI)),
    .wdata(pwdata),
    .q(fwRightsHigh)
  );

  // Read mux of the guard registers; narrow ones sit in the low bits.
  always_comb
  begin
    ownRdata = `ZERO32;
    unique case (cls.own)
      OWN_EXCH_BASE: ownRdata = {16'h0000, exchBase};
      OWN_EXCH_SIZE: ownRdata = {16'h0000, exchSize};
      OWN_STAB_LO: ownRdata = {16'h0000, stabLo};
      OWN_STAB_HI: ownRdata = {16'h0000, stabHi};
      OWN_FW_LO: ownRdata = fwRightsLow;
      OWN_FW_HI: ownRdata = fwRightsHigh;
      OWN_NONE: ownRdata = `ZERO32;
    endcase
  end

  // Answer computation: one wait state, then data and error stand for
  // the single cycle in which pready is high.
  always_comb
  begin
    state_d = state_q;
    prdata_d = `ZERO32;
    pslverr_d = 1'b0;
    unique case (state_q)
      ST_IDLE:
      begin
        if (accessPhase)
        begin
          state_d = ST_ANSWER;
          pslverr_d = !allowed;
          if (!pwrite && readOk)
            prdata_d = (cls.own == OWN_NONE) ? sfrRdata : ownRdata;
          else
            prdata_d = `DENY_RDATA;
        end
      end
      ST_ANSWER:
      begin
        state_d = ST_IDLE;
      end
    endcase
  end

  // Answer registers.
  always_ff @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      state_q <= ST_IDLE;
      prdata_q <= `ZERO32;
      pslverr_q <= 1'b0;
    end
    else
    begin
      state_q <= state_d;
      prdata_q <= prdata_d;
      pslverr_q <= pslverr_d;
    end
  end

  // Bus outputs.
  assign pready = (state_q == ST_ANSWER);
  assign prdata = prdata_q;
  assign pslverr = pslverr_q;

  // The partition itself has no register and no write path here.
  assign exchangeBase = exchBase;
  assign exchangeSize = exchSize;

  // The table words live in ordinary memory and are guarded by the
  // memory rights of their segment, not by this block.
  assign segTableAddr = {stabHi, stabLo};
endmodule

/* tb/sfr_space_model.sv */
/*
  Downstream register space: a word array that answers in the strobe
  cycle. Assumes at most one strobe per two cycles from the guard.
*/
`timescale 1ns/1ps
module sfr_space_model (
  // Clock.
  input wire logic sys_clk,
  // Strobes, address and data from the guard.
  input wire logic sfrReadEn,
  input wire logic sfrWriteEn,
  input wire logic [11:0] sfrAddr,
  input wire logic [31:0] sfrWdata,
  // Read answer.
  output logic [31:0] sfrRdata
);
  logic [31:0] mem [0:1023]; // One word per register.
  logic [31:0] lastRd; // Last answer given.
  // Each word starts as a marker of its own index.
  initial
  begin
    for (int i = 0; i < 1024; i++)
      mem[i] = 32'hD000_0000 | i;
    lastRd = 32'h0;
  end
  // Writes land at the strobe edge; reads are remembered.
  always @(posedge sys_clk)
  begin
    if (sfrWriteEn)
      mem[sfrAddr[11:2]] <= sfrWdata;
    if (sfrReadEn)
      lastRd <= sfrRdata;
  end
  // Idle data is inverted so a stale answer never looks valid.
  assign sfrRdata = sfrReadEn ? mem[sfrAddr[11:2]] : ~lastRd;
endmodule

/* tb/sfr_mode_access_guard_properties.sv */
/*
  Port assertions for the access guard.
  Assumes it is bound to the guard's top module.
*/
`timescale 1ns/1ps
module sfr_mode_access_guard_properties
  import sfr_guard_pkg::*;
(
  // Clock and reset.
  input wire logic sys_clk,
  input wire logic rst_b,
  // APB.
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // Attributes.
  input wire cpu_mode_e cpuMode,
  input wire logic [31:0] segReadRights,
  // Downstream and configuration.
  input wire logic sfrReadEn,
  input wire logic sfrWriteEn,
  input wire logic [31:0] segTableAddr,
  input wire logic [15:0] exchangeBase
);
  logic acc; // First access cycle.
  logic rd; // First access cycle of a read.
  logic [3:0] grp; // Register group.
  logic sysW; // Write in system, boot or test mode.
  logic tblW; // System mode write into the segmentation group.
  logic exchW; // Write aimed at the exchange base register.
  assign acc = psel && penable && !pready;
  assign rd = acc && !pwrite;
  assign grp = paddr[11:8];
  assign sysW = acc && pwrite && cpuMode inside {MODE_SYS, MODE_BOOT,
    MODE_TEST};
  assign tblW = sysW && (cpuMode == MODE_SYS) && (grp == 4'h2);
  assign exchW = sysW && (paddr == 12'h108);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_b);
  mmu_refuse_a: assert property (acc && grp == 4'h2 &&
    cpuMode != MODE_SYS |-> !sfrReadEn && !sfrWriteEn ##1 pslverr)
    else $error("Segment setup reached outside system mode");
  protect_hidden_a: assert property (rd &&
    paddr inside {12'h110, 12'h114, 12'h118} |=> pslverr && prdata == 0)
    else $error("Protect register was readable");
  random_ro_a: assert property (acc && pwrite && paddr == 12'h504
    |-> !sfrWriteEn ##1 pslverr) else $error("Random value written");
  key_hidden_a: assert property (rd &&
    paddr inside {12'h508, 12'h50C} |-> !sfrReadEn ##1 prdata == 0)
    else $error("Key register was readable");
  general_open_a: assert property (acc && grp == 4'h0 &&
    cpuMode inside {[MODE_BOOT:MODE_USER]}
    |-> (pwrite ? sfrWriteEn : sfrReadEn) ##1 pready && !pslverr)
    else $error("General register refused");
  user_rights_a: assert property (rd && cpuMode == MODE_USER &&
    grp == 4'h5 && !paddr[7] && paddr[6:2] != 5'h02 && paddr[6:2] != 5'h03
    |-> sfrReadEn == segReadRights[paddr[6:2]])
    else $error("User read ignored segment rights");
  clk_sel_a: assert property (rd && cpuMode == MODE_CLOS &&
    paddr == 12'h500 |-> sfrReadEn ##1 !pslverr)
    else $error("Clock select read refused");
  table_guard_a: assert property ($changed(segTableAddr)
    |-> $past(tblW)) else $error("Segment table moved without right");
  exch_guard_a: assert property (!$stable(exchangeBase)
    |-> $past(exchW)) else $error("Exchange base moved without right");
  reset_zero_a: assert property ($rose(rst_b)
    |-> segTableAddr == 0) else $error("Segment table not cleared");
endmodule
bind sfr_mode_access_guard sfr_mode_access_guard_properties chk (
  .sys_clk(sys_clk), .rst_b(rst_b), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .prdata(prdata), .pready(pready),
  .pslverr(pslverr), .cpuMode(cpuMode), .segReadRights(segReadRights),
  .sfrReadEn(sfrReadEn), .sfrWriteEn(sfrWriteEn),
  .segTableAddr(segTableAddr), .exchangeBase(exchangeBase));

/* tb/sfr_mode_access_guard_tb_top.sv */
/*
  Self-checking bench: APB calls in every CPU mode, expected values.
  Assumes the downstream model presets each word to its own marker.
*/
`timescale 1ns/1ps
module sfr_mode_access_guard_tb_top;
  import sfr_guard_pkg::*;
  logic sys_clk = 1'b0;
  logic rst_b = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  cpu_mode_e cpuMode = MODE_BOOT;
  logic [31:0] segReadRights = 32'h0;
  logic [31:0] segWriteRights = 32'h0;
  logic [31:0] prdata, sfrWdata, sfrRdata, segTableAddr;
  logic pready, pslverr, sfrReadEn, sfrWriteEn;
  logic [11:0] sfrAddr;
  logic [15:0] exchangeBase, exchangeSize;
  int n_errors = 0;
  int total_checks = 0;
  int cycles = 0;
  sfr_mode_access_guard dut (.sys_clk(sys_clk), .rst_b(rst_b),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .cpuMode(cpuMode), .segReadRights(segReadRights),
    .segWriteRights(segWriteRights), .sfrReadEn(sfrReadEn),
    .sfrWriteEn(sfrWriteEn), .sfrAddr(sfrAddr), .sfrWdata(sfrWdata),
    .sfrRdata(sfrRdata), .segTableAddr(segTableAddr),
    .exchangeBase(exchangeBase), .exchangeSize(exchangeSize));
  sfr_space_model model (.sys_clk(sys_clk), .sfrReadEn(sfrReadEn),
    .sfrWriteEn(sfrWriteEn), .sfrAddr(sfrAddr), .sfrWdata(sfrWdata),
    .sfrRdata(sfrRdata));
  // Clock at 40 MHz.
  initial
  begin
    forever #12.5 sys_clk = ~sys_clk;
  end
  // Prints the counts and the verdict, then stops.
  task automatic finish_test;
    $display("Checks %0d, mismatches %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  // A hang counts as a mismatch.
  always @(posedge sys_clk)
  begin
    cycles++;
    if (cycles == 3000)
    begin
      n_errors++;
      finish_test();
    end
  end
  // Compares a seen value with the expected one.
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("Error at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  // Word that the model holds before any write.
  function automatic logic [31:0] dv(input logic [11:0] a);
    return 32'hD000_0000 | {22'h0, a[11:2]};
  endfunction
  // One APB transfer; holds the request until pready is sampled high or 8 cycles pass.
  task automatic apb(input logic wr, input logic [11:0] a,
    input logic [31:0] d, input logic [31:0] expD, input logic expE);
    int n;
    n = 0;
    @(posedge sys_clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge sys_clk);
    penable <= 1'b1;
    do
    begin
      @(posedge sys_clk);
      n++;
    end
    while (pready !== 1'b1 && n < 8);
    check({31'h0, pready}, 32'h1);
    check({31'h0, pslverr}, {31'h0, expE});
    if (!wr)
      check(prdata, expD);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // Main sequence.
  initial
  begin
    repeat (20) @(posedge sys_clk);
    rst_b <= 1'b1;
    check(segTableAddr, 32'h0);
    check({exchangeBase, exchangeSize}, 32'h0);
    cpuMode <= MODE_SYS;
    apb(1, 12'h200, 32'h1234, 0, 0);
    apb(1, 12'h204, 32'hABCD, 0, 0);
    check(segTableAddr, 32'hABCD_1234);
    apb(1, 12'h108, 32'h40, 0, 0);
    apb(0, 12'h108, 0, 32'h40, 0);
    apb(0, 12'h510, 0, dv(12'h510), 0);
    apb(1, 12'h508, 32'h1111_2222, 0, 0);
    apb(0, 12'h508, 0, 32'h0, 1);
    apb(1, 12'h504, 32'h1, 0, 1);
    apb(0, 12'h504, 0, dv(12'h504), 0);
    for (int i = 0; i < 3; i++)
      apb(0, 12'h110 + 12'(4 * i), 0, 32'h0, 1);
    apb(1, 12'h300, 32'h40, 0, 0);
    apb(1, 12'h304, 32'h80, 0, 0);
    $display("System mode test done");
    cpuMode <= MODE_USER;
    segReadRights <= 32'h10;
    segWriteRights <= 32'h20;
    apb(1, 12'h200, 32'hFFFF, 0, 1);
    check(segTableAddr, 32'hABCD_1234);
    apb(1, 12'h108, 32'h99, 0, 1);
    check({16'h0, exchangeBase}, 32'h40);
    apb(0, 12'h104, 0, dv(12'h104), 0);
    apb(0, 12'h100, 0, 32'h0, 1);
    apb(0, 12'h510, 0, dv(12'h510), 0);
    apb(0, 12'h514, 0, 32'h0, 1);
    apb(1, 12'h514, 32'h7777_0000, 0, 0);
    apb(1, 12'h510, 32'h1, 0, 1);
    $display("User mode test done");
    cpuMode <= MODE_CLOS;
    apb(0, 12'h300, 0, 32'h40, 0);
    apb(1, 12'h304, 32'hFFFF_FFFF, 0, 1);
    apb(1, 12'h404, 32'hCAFE_0001, 0, 0);
    apb(0, 12'h404, 0, 32'hCAFE_0001, 0);
    apb(0, 12'h518, 0, dv(12'h518), 0);
    apb(0, 12'h51C, 0, 32'h0, 1);
    apb(1, 12'h51C, 32'h3, 0, 0);
    apb(1, 12'h518, 32'h3, 0, 1);
    apb(0, 12'h500, 0, dv(12'h500), 0);
    apb(0, 12'h104, 0, dv(12'h104), 0);
    apb(0, 12'h204, 0, 32'h0, 1);
    $display("Contactless mode test done");
    for (int m = 0; m < 5; m++)
    begin
      cpuMode <= cpu_mode_e'(3'(m));
      apb(1, 12'h010, 32'h0100_0000 | m, 0, 0);
      apb(0, 12'h010, 0, 32'h0100_0000 | m, 0);
    end
    cpuMode <= MODE_BOOT;
    apb(1, 12'h200, 32'h5555, 0, 1);
    check(segTableAddr, 32'hABCD_1234);
    apb(1, 12'h10C, 32'h5555, 0, 0);
    check({16'h0, exchangeSize}, 32'h5555);
    apb(0, 12'h51C, 0, 32'h3, 0);
    apb(0, 12'h50C, 0, 32'h0, 1);
    cpuMode <= MODE_TEST;
    apb(0, 12'h514, 0, 32'h7777_0000, 0);
    cpuMode <= cpu_mode_e'(3'b111);
    apb(0, 12'h010, 0, 32'h0, 1);
    $display("General and open mode test done");
    rst_b <= 1'b0;
    repeat (3) @(posedge sys_clk);
    check(segTableAddr, 32'h0);
    check({exchangeBase, exchangeSize}, 32'h0);
    rst_b <= 1'b1;
    cpuMode <= MODE_SYS;
    apb(0, 12'h304, 0, 32'h0, 0);
    $display("Reset test done");
    finish_test();
  end
endmodule
